// ---- design/reset_and_stop_recovery.sv ----
// Reset sequencer, stop-mode recovery and reset-cause register behind AXI4-Lite
`timescale 1ns/10ps
module reset_and_stop_recovery #(
    parameter logic [7:0] RST_TMO = rst_pkg::RST_TMO_CYC
) (
    // Clock and reset
    input  wire logic                        aclk,
    input  wire logic                        aresetn,
    // Register bus
    input  wire rst_pkg::axi_in_s            axi_in,
    output rst_pkg::axi_out_s                axi_out,
    // Asynchronous pins
    input  wire logic                        reset_pin_n,
    input  wire logic                        wd_osc,
    input  wire logic [rst_pkg::GPIO_W-1:0]  gpio_in,
    // Core and watchdog events
    input  wire logic                        stop_exec,
    input  wire logic                        dbg_rst_req,
    input  wire logic                        wdt_timeout,
    input  wire logic                        wdt_irq_mode,
    input  wire logic                        cpu_irq_en,
    // Program memory read
    output logic                             pm_rd,
    output logic [15:0]                      pm_addr,
    input  wire logic [7:0]                  pm_data,
    // Reset and core control
    output logic                             sys_rst_n,
    output logic                             core_hold,
    output logic                             stop_mode,
    output logic                             ocd_rst_n,
    output logic [15:0]                      pc,
    output logic                             pc_load,
    output logic                             wdt_irq,
    output logic                             irq
);

    rst_pkg::state_s s_r;
    rst_pkg::state_s s_nxt;

    // Outputs straight from the state register
    assign axi_out   = s_r.ax;
    assign pm_rd     = s_r.pm_rd;
    assign pm_addr   = s_r.pm_addr;
    assign sys_rst_n = s_r.sys_rst_n;
    assign core_hold = s_r.core_hold;
    assign stop_mode = s_r.stop_mode;
    assign ocd_rst_n = s_r.ocd_rst_n;
    assign pc        = s_r.pc;
    assign pc_load   = s_r.pc_load;
    assign wdt_irq   = s_r.wdt_irq;
    assign irq       = s_r.irq;

    // Next-state logic
    always_comb begin
        rst_pkg::state_s n;
        logic [7:0]      tmo_last;
        logic [11:0]     ra;
        logic [11:0]     wa;
        logic            osc_rise;
        logic [rst_pkg::GPIO_W-1:0] gp_edge;
        logic            go_rst;
        logic [3:0]      go_pend;
        n        = s_r;
        tmo_last = RST_TMO - 8'h01;
        ra       = {axi_in.araddr[11:2], 2'h0};
        wa       = {s_r.awaddr[11:2], 2'h0};
        go_rst   = 1'b0;
        go_pend  = rst_pkg::P_NONE;
        osc_rise = s_r.osc_q & ~s_r.osc_p;
        gp_edge  = (s_r.gp_q ^ s_r.gp_p) & s_r.gp_en;

        // Two-stage synchronisers; first stages feed no logic, edge detects also use the delayed osc_p and gp_p
        n.pin_m = reset_pin_n;
        n.pin_q = s_r.pin_m;
        n.osc_m = wd_osc;
        n.osc_q = s_r.osc_m;
        n.osc_p = s_r.osc_q;
        n.gp_m  = gpio_in;
        n.gp_q  = s_r.gp_m;
        n.gp_p  = s_r.gp_q;

        // Pin filter counts consecutive low samples, saturates at four
        if (s_r.pin_q) begin
            n.flt = 3'h0;
        end else if (s_r.flt != rst_pkg::FLT_LEN) begin
            n.flt = s_r.flt + 3'h1;
        end

        // Write channel: address and data taken in either order
        if (s_r.ax.bvalid && axi_in.bready) begin
            n.ax.bvalid = 1'b0;
        end
        if (axi_in.awvalid && s_r.ax.awready) begin
            n.aw_got = 1'b1;
            n.awaddr = axi_in.awaddr;
        end
        if (axi_in.wvalid && s_r.ax.wready) begin
            n.w_got = 1'b1;
            n.wdata = axi_in.wdata;
            n.wstrb = axi_in.wstrb;
        end
        if (s_r.aw_got && s_r.w_got) begin
            n.aw_got    = 1'b0;
            n.w_got     = 1'b0;
            n.ax.bvalid = 1'b1;
            n.ax.bresp  = rst_pkg::RESP_OK;
            unique case (wa)
                rst_pkg::A_CTRL: begin
                    if (s_r.wstrb[0] && s_r.wdata[rst_pkg::CB_DBG]) begin
                        n.dbg_req = 1'b1;
                    end
                end
                rst_pkg::A_GPEN: begin
                    if (s_r.wstrb[0]) begin
                        n.gp_en = s_r.wdata[rst_pkg::GPIO_W-1:0];
                    end
                end
                rst_pkg::A_IST: begin
                    if (s_r.wstrb[0]) begin
                        n.ist = s_r.ist & ~s_r.wdata[3:0];
                    end
                end
                rst_pkg::A_IMASK: begin
                    if (s_r.wstrb[0]) begin
                        n.imask = s_r.wdata[3:0];
                    end
                end
                rst_pkg::A_CAUSE: begin
                    // Read-only, write accepted and ignored
                end
                default: begin
                    n.ax.bresp = rst_pkg::RESP_SLV;
                end
            endcase
        end
        n.ax.awready = ~n.aw_got & ~n.ax.bvalid;
        n.ax.wready  = ~n.w_got & ~n.ax.bvalid;
        if (dbg_rst_req) begin
            n.dbg_req = 1'b1;
        end

        // Read channel; cause read has a clearing side effect
        if (s_r.ax.rvalid && axi_in.rready) begin
            n.ax.rvalid = 1'b0;
        end
        if (axi_in.arvalid && s_r.ax.arready) begin
            n.ax.rvalid = 1'b1;
            n.ax.rresp  = rst_pkg::RESP_OK;
            n.ax.rdata  = 32'h0000_0000;
            unique case (ra)
                rst_pkg::A_CTRL: begin
                    n.ax.rdata[rst_pkg::CB_DBG]   = s_r.dbg_req;
                    n.ax.rdata[rst_pkg::CB_STOP]  = s_r.stop_mode;
                    n.ax.rdata[rst_pkg::CB_RESET] = ~s_r.sys_rst_n;
                end
                rst_pkg::A_GPEN: begin
                    n.ax.rdata[rst_pkg::GPIO_W-1:0] = s_r.gp_en;
                end
                rst_pkg::A_IST: begin
                    n.ax.rdata[3:0] = s_r.ist;
                end
                rst_pkg::A_IMASK: begin
                    n.ax.rdata[3:0] = s_r.imask;
                end
                rst_pkg::A_CAUSE: begin
                    n.ax.rdata[7:4] = s_r.cause;
                    n.cause         = rst_pkg::P_NONE;
                end
                default: begin
                    n.ax.rresp = rst_pkg::RESP_SLV;
                end
            endcase
        end
        n.ax.arready = ~n.ax.rvalid;

        // Sequencer; cause updates come after bus clears so a set wins
        n.pc_load = 1'b0;
        n.wdt_irq = 1'b0;
        unique case (s_r.st)
            rst_pkg::ST_RESET: begin
                n.dbg_req = 1'b0;
                if (s_r.cnt != tmo_last) begin
                    n.cnt = s_r.cnt + 8'h01;
                end else if (s_r.pin_q) begin
                    n.st    = rst_pkg::ST_FETCH_HI;
                    n.cause = s_r.pend;
                end
            end
            rst_pkg::ST_RUN: begin
                if (s_r.dbg_req) begin
                    go_rst  = 1'b1;
                    go_pend = rst_pkg::P_POR;
                    n.ist[rst_pkg::EV_DBG] = 1'b1;
                end else if (wdt_timeout && !wdt_irq_mode) begin
                    go_rst  = 1'b1;
                    go_pend = rst_pkg::P_WDT;
                    n.ist[rst_pkg::EV_WDT] = 1'b1;
                end else if (stop_exec) begin
                    n.st = rst_pkg::ST_STOP;
                end
            end
            rst_pkg::ST_STOP: begin
                n.cnt = 8'h00;
                if (s_r.dbg_req) begin
                    go_rst  = 1'b1;
                    go_pend = rst_pkg::P_POR;
                    n.ist[rst_pkg::EV_DBG] = 1'b1;
                end else if (wdt_timeout) begin
                    // Interrupt mode remembered for after recovery
                    n.st       = rst_pkg::ST_REC_OSC;
                    n.pend     = rst_pkg::P_STOP | rst_pkg::P_WDT;
                    n.wdi_pend = wdt_irq_mode;
                    n.ist[rst_pkg::EV_WDT] = 1'b1;
                end else if (|gp_edge) begin
                    n.st       = rst_pkg::ST_REC_OSC;
                    n.pend     = rst_pkg::P_STOP;
                    n.wdi_pend = 1'b0;
                end
            end
            rst_pkg::ST_REC_OSC: begin
                if (osc_rise) begin
                    if (s_r.cnt == rst_pkg::OSC_CYC - 8'h01) begin
                        n.st  = rst_pkg::ST_REC_SYS;
                        n.cnt = 8'h00;
                    end else begin
                        n.cnt = s_r.cnt + 8'h01;
                    end
                end
            end
            rst_pkg::ST_REC_SYS: begin
                if (s_r.cnt == rst_pkg::SYS_CYC - 8'h01) begin
                    n.st    = rst_pkg::ST_FETCH_HI;
                    n.cause = s_r.pend;
                    n.ist[rst_pkg::EV_STOP] = 1'b1;
                end else begin
                    n.cnt = s_r.cnt + 8'h01;
                end
            end
            rst_pkg::ST_FETCH_HI: begin
                n.st = rst_pkg::ST_FETCH_LO;
            end
            rst_pkg::ST_FETCH_LO: begin
                n.st        = rst_pkg::ST_LOAD;
                n.pc[15:8]  = pm_data;
            end
            rst_pkg::ST_LOAD: begin
                n.st       = rst_pkg::ST_RUN;
                n.pc[7:0]  = pm_data;
                n.pc_load  = 1'b1;
                n.wdt_irq  = s_r.wdi_pend & cpu_irq_en;
                n.wdi_pend = 1'b0;
            end
        endcase

        // Filtered pin overrides every other source
        if (n.flt == rst_pkg::FLT_LEN && s_r.st != rst_pkg::ST_RESET) begin
            go_rst  = 1'b1;
            go_pend = rst_pkg::P_EXT;
            n.ist[rst_pkg::EV_EXT] = 1'b1;
        end
        if (go_rst) begin
            n.st       = rst_pkg::ST_RESET;
            n.cnt      = 8'h00;
            n.pend     = go_pend;
            n.wdi_pend = 1'b0;
        end

        // Recovery holds only the core; peripherals keep their state
        n.sys_rst_n = (n.st != rst_pkg::ST_RESET);
        n.core_hold = (n.st != rst_pkg::ST_RUN) && (n.st != rst_pkg::ST_STOP);
        n.stop_mode = (n.st == rst_pkg::ST_STOP) || (n.st == rst_pkg::ST_REC_OSC)
                      || (n.st == rst_pkg::ST_REC_SYS);
        n.pm_rd     = (n.st == rst_pkg::ST_FETCH_HI) || (n.st == rst_pkg::ST_FETCH_LO);
        n.pm_addr   = (n.st == rst_pkg::ST_FETCH_LO) ? rst_pkg::VEC_LO : rst_pkg::VEC_HI;
        n.ocd_rst_n = 1'b1;
        n.irq       = |(n.ist & n.imask);
        s_nxt = n;
    end

    // State register; only the bus reset drives ocd_rst_n low; it and a debugger reset both load the power-on cause
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_r           <= '0;
            s_r.st        <= rst_pkg::ST_RESET;
            s_r.pin_m     <= 1'b1;
            s_r.pin_q     <= 1'b1;
            s_r.cause     <= rst_pkg::CAUSE_RST[7:4];
            s_r.pend      <= rst_pkg::P_POR;
            s_r.core_hold <= 1'b1;
            s_r.pm_addr   <= rst_pkg::VEC_HI;
        end else begin
            s_r <= s_nxt;
        end
    end

    // Checks
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    sequence seq_ext_entry;
        s_r.st != rst_pkg::ST_RESET ##1
        (s_r.st == rst_pkg::ST_RESET && s_r.pend == rst_pkg::P_EXT);
    endsequence

    // Independent dwell count so the check does not lean on the sequencer count
    logic [7:0] sys_dwell_r;
    always_ff @(posedge aclk) begin
        if (!aresetn || s_r.st != rst_pkg::ST_REC_SYS) begin
            sys_dwell_r <= 8'h00;
        end else begin
            sys_dwell_r <= sys_dwell_r + 8'h01;
        end
    end

    sequence seq_sys_hold;
        s_r.st == rst_pkg::ST_REC_SYS ##1 s_r.st != rst_pkg::ST_REC_SYS;
    endsequence

    a_pin_filter: assert property (
        seq_ext_entry |-> $past(s_r.flt) == 3'h3 && !$past(s_r.pin_q, 2))
        else $error("pin reset entered without four low samples");

    a_hold_low: assert property (
        s_r.st == rst_pkg::ST_RESET && !s_r.pin_q |=> s_r.st == rst_pkg::ST_RESET)
        else $error("reset left while pin low");

    a_fast_exit: assert property (
        s_r.st == rst_pkg::ST_RESET && s_r.cnt == RST_TMO - 8'h01 && s_r.pin_q
        |=> s_r.st == rst_pkg::ST_FETCH_HI && s_r.sys_rst_n)
        else $error("no exit at pin release after time-out");

    a_ext_cause: assert property (
        s_r.st == rst_pkg::ST_RESET && s_r.pend == rst_pkg::P_EXT
        ##1 s_r.st == rst_pkg::ST_FETCH_HI |-> s_r.cause == rst_pkg::P_EXT)
        else $error("external cause not recorded");

    a_dbg_keep: assert property (
        s_r.st == rst_pkg::ST_RESET && s_r.pend == rst_pkg::P_POR && $past(aresetn)
        |-> s_r.ocd_rst_n && !s_r.sys_rst_n)
        else $error("debugger reset wrongly applied");

    a_dbg_selfclr: assert property (
        s_r.st == rst_pkg::ST_RESET |=> !s_r.dbg_req)
        else $error("debugger request not cleared in reset");

    a_stop_enter: assert property (
        s_r.st == rst_pkg::ST_RUN && stop_exec && !s_r.dbg_req && !wdt_timeout
        && s_r.pin_q |=> s_r.st == rst_pkg::ST_STOP && s_r.stop_mode)
        else $error("stop not entered");

    a_osc_count: assert property (
        s_r.st == rst_pkg::ST_REC_OSC ##1 s_r.st == rst_pkg::ST_REC_SYS
        |-> $past(s_r.cnt) == 8'h41 && s_r.core_hold)
        else $error("oscillator hold not 66 edges");

    a_sys_count: assert property (disable iff (!aresetn || !s_r.pin_q)
        seq_sys_hold |-> s_r.st == rst_pkg::ST_FETCH_HI && s_r.cause[2]
        && sys_dwell_r == rst_pkg::SYS_CYC)
        else $error("system clock hold not 16 cycles");

    a_vector_load: assert property (
        s_r.st == rst_pkg::ST_FETCH_LO |-> s_r.pm_addr == 16'h0003
        ##1 (s_r.pc[15:8] == $past(pm_data) ##1 s_r.pc_load))
        else $error("reset vector not loaded");

    a_cause_rdclr: assert property (
        axi_in.arvalid && s_r.ax.arready && axi_in.araddr == rst_pkg::A_CAUSE
        && s_r.st == rst_pkg::ST_RUN |=> s_r.cause == 4'h0 && s_r.ax.rvalid)
        else $error("cause not cleared by read");

endmodule

// ---- shared/rst_pkg.sv ----
// Register map, constants and state layout of the reset and stop recovery block
package rst_pkg;

    // Bus and port widths
    localparam int AW     = 12;
    localparam int GPIO_W = 8;

    // Register byte addresses
    localparam logic [11:0] A_CTRL  = 12'h000;
    localparam logic [11:0] A_GPEN  = 12'h004;
    localparam logic [11:0] A_IST   = 12'h008;
    localparam logic [11:0] A_IMASK = 12'h00C;
    localparam logic [11:0] A_CAUSE = 12'hFF0;

    // Control register bit positions
    localparam int CB_DBG   = 0;
    localparam int CB_STOP  = 1;
    localparam int CB_RESET = 2;

    // Reset cause codes, upper nibble of reset_cause_status
    localparam logic [3:0] P_POR  = 4'h8;
    localparam logic [3:0] P_STOP = 4'h4;
    localparam logic [3:0] P_WDT  = 4'h2;
    localparam logic [3:0] P_EXT  = 4'h1;
    localparam logic [3:0] P_NONE = 4'h0;
    localparam logic [7:0] CAUSE_RST = 8'h80;

    // Interrupt status bit positions
    localparam int EV_EXT  = 0;
    localparam int EV_DBG  = 1;
    localparam int EV_STOP = 2;
    localparam int EV_WDT  = 3;

    // Cycle counts
    localparam logic [2:0] FLT_LEN     = 3'h4;
    localparam logic [7:0] OSC_CYC     = 8'h42;
    localparam logic [7:0] SYS_CYC     = 8'h10;
    localparam logic [7:0] RST_TMO_CYC = 8'h20;

    // Reset vector bytes in program memory
    localparam logic [15:0] VEC_HI = 16'h0002;
    localparam logic [15:0] VEC_LO = 16'h0003;

    // Bus responses
    localparam logic [1:0] RESP_OK  = 2'h0;
    localparam logic [1:0] RESP_SLV = 2'h2;

    typedef enum logic [2:0] {
        ST_RESET, ST_RUN, ST_STOP, ST_REC_OSC,
        ST_REC_SYS, ST_FETCH_HI, ST_FETCH_LO, ST_LOAD
    } seq_e;

    // AXI4-Lite master to slave
    typedef struct packed {
        logic [AW-1:0] awaddr;
        logic          awvalid;
        logic [31:0]   wdata;
        logic [3:0]    wstrb;
        logic          wvalid;
        logic          bready;
        logic [AW-1:0] araddr;
        logic          arvalid;
        logic          rready;
    } axi_in_s;

    // AXI4-Lite slave to master
    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } axi_out_s;

    // Whole state of the block
    typedef struct packed {
        seq_e              st;
        logic [7:0]        cnt;
        logic              pin_m;
        logic              pin_q;
        logic [2:0]        flt;
        logic              osc_m;
        logic              osc_q;
        logic              osc_p;
        logic [GPIO_W-1:0] gp_m;
        logic [GPIO_W-1:0] gp_q;
        logic [GPIO_W-1:0] gp_p;
        logic [GPIO_W-1:0] gp_en;
        logic [3:0]        cause;
        logic [3:0]        pend;
        logic              dbg_req;
        logic              wdi_pend;
        logic [3:0]        ist;
        logic [3:0]        imask;
        logic              irq;
        logic              aw_got;
        logic              w_got;
        logic [AW-1:0]     awaddr;
        logic [31:0]       wdata;
        logic [3:0]        wstrb;
        axi_out_s          ax;
        logic              sys_rst_n;
        logic              core_hold;
        logic              stop_mode;
        logic              pm_rd;
        logic [15:0]       pm_addr;
        logic [15:0]       pc;
        logic              pc_load;
        logic              wdt_irq;
        logic              ocd_rst_n;
    } state_s;

endpackage

// ---- testbench/stim_partner.sv ----
// Reset pin driver, watchdog oscillator and vector memory model
`timescale 1ns/10ps
module stim_partner #(
    parameter real         HALF = 7.3,
    parameter logic [15:0] VEC  = 16'h5A3C
) (
    // Clock and memory port
    input  wire logic        aclk,
    input  wire logic        pm_rd,
    input  wire logic [15:0] pm_addr,
    // Driven pins
    output logic             reset_pin_n,
    output logic             wd_osc,
    output logic [7:0]       pm_data
);
    // Free-running oscillator, phase unrelated to aclk
    initial wd_osc = 1'b0;
    always #HALF wd_osc = ~wd_osc;
    initial reset_pin_n = 1'b1;
    initial pm_data = 8'h00;
    // One-cycle read; unselected memory toggles so stale data never matches
    always @(posedge aclk)
        pm_data <= !pm_rd ? ~pm_data : pm_addr == rst_pkg::VEC_HI ? VEC[15:8]
                 : pm_addr == rst_pkg::VEC_LO ? VEC[7:0] : ~pm_data;
    // Pin low for n cycles, then released to its pull-up
    task automatic pin_low(input int n);
        reset_pin_n <= 1'b0;
        repeat (n) @(posedge aclk);
        reset_pin_n <= 1'b1;
    endtask
endmodule

// ---- testbench/tb_reset_and_stop_recovery.sv ----
// Self-checking bench for the reset and stop recovery block
`timescale 1ns/10ps
module tb_reset_and_stop_recovery;
    localparam logic [15:0] VEC  = 16'h5A3C;
    localparam real         HALF = 7.3;
    // Recovery window: 65 to 66 oscillator periods, 16 clocks, sync and fetch
    localparam int          LO   = int'(65.0 * 2.0 * HALF / 5.0) + 16;
    localparam int          HI   = int'(66.0 * 2.0 * HALF / 5.0) + 32;
    logic              aclk, aresetn, reset_pin_n, wd_osc, pm_rd, sys_rst_n, core_hold;
    logic              stop_exec, dbg_rst_req, wdt_timeout, wdt_irq_mode, cpu_irq_en;
    logic              stop_mode, ocd_rst_n, pc_load, wdt_irq, irq, rst_seen, ocd_seen;
    logic [7:0]        gpio_in, pm_data, gp;
    logic [15:0]       pm_addr, pc;
    logic [31:0]       rd;
    logic [1:0]        rr;
    rst_pkg::axi_in_s  ai;
    rst_pkg::axi_out_s ao;
    int                errors, n_checks, cyc, t0;

    reset_and_stop_recovery #(.RST_TMO(8'h06)) i_dut (
        .aclk(aclk), .aresetn(aresetn), .axi_in(ai), .axi_out(ao),
        .reset_pin_n(reset_pin_n), .wd_osc(wd_osc), .gpio_in(gpio_in),
        .stop_exec(stop_exec), .dbg_rst_req(dbg_rst_req), .wdt_timeout(wdt_timeout),
        .wdt_irq_mode(wdt_irq_mode), .cpu_irq_en(cpu_irq_en), .pm_rd(pm_rd),
        .pm_addr(pm_addr), .pm_data(pm_data), .sys_rst_n(sys_rst_n),
        .core_hold(core_hold), .stop_mode(stop_mode), .ocd_rst_n(ocd_rst_n),
        .pc(pc), .pc_load(pc_load), .wdt_irq(wdt_irq), .irq(irq));

    stim_partner #(.HALF(HALF), .VEC(VEC)) i_model (
        .aclk(aclk), .pm_rd(pm_rd), .pm_addr(pm_addr),
        .reset_pin_n(reset_pin_n), .wd_osc(wd_osc), .pm_data(pm_data));

    always #2.5 aclk = ~aclk;

    // Hang guard and reset monitors; the debugger must never see reset
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (sys_rst_n === 1'b0) rst_seen <= 1'b1;
        if (cyc > 20 && ocd_rst_n !== 1'b1) ocd_seen <= 1'b1;
        if (cyc == 10000) begin
            errors++;
            complete_run();
        end
    end

    function automatic logic [31:0] exp_cause(input logic [3:0] c);
        return {24'h0, c, 4'h0};
    endfunction

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_checks++;
        if (g !== e) begin
            errors++;
            $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    task automatic complete_run();
        $display("checks=%0d errors=%0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // Address and data offered together, each released when taken
    task automatic axi_wr(input logic [11:0] a, input logic [31:0] d);
        bit aw, w;
        @(posedge aclk);
        aw = 0;
        w = 0;
        ai.awaddr <= a;
        ai.wdata <= d;
        ai.wstrb <= 4'hF;
        {ai.awvalid, ai.wvalid, ai.bready} <= 3'h7;
        do begin
            @(posedge aclk);
            if (!aw && ao.awready === 1'b1) begin
                aw = 1;
                ai.awvalid <= 1'b0;
            end
            if (!w && ao.wready === 1'b1) begin
                w = 1;
                ai.wvalid <= 1'b0;
            end
        end while (!(aw && w));
        do @(posedge aclk); while (ao.bvalid !== 1'b1);
        chk(ao.bresp, rst_pkg::RESP_OK);
        ai.bready <= 1'b0;
    endtask

    task automatic axi_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        ai.araddr <= a;
        {ai.arvalid, ai.rready} <= 2'h3;
        forever begin
            @(posedge aclk);
            if (ao.rvalid === 1'b1) break;
            if (ao.arready === 1'b1) ai.arvalid <= 1'b0;
        end
        d = ao.rdata;
        r = ao.rresp;
        ai.rready <= 1'b0;
    endtask

    task automatic wait_load();
        do @(posedge aclk); while (pc_load !== 1'b1);
    endtask

    // Enter stop, wake by port pin (0), watchdog in reset mode (1) or interrupt mode (2)
    task automatic stop_cycle(input int src, input logic ie);
        stop_exec <= 1'b1;
        @(posedge aclk);
        stop_exec <= 1'b0;
        repeat (3) @(posedge aclk);
        chk(stop_mode, 1'b1);
        gpio_in <= gpio_in ^ ~gp;
        repeat (8) @(posedge aclk);
        chk(stop_mode, 1'b1);
        cpu_irq_en <= ie;
        wdt_irq_mode <= (src == 2);
        if (src == 0) gpio_in <= gpio_in ^ 8'h01;
        else wdt_timeout <= 1'b1;
        rst_seen <= 1'b0;
        t0 = cyc;
        @(posedge aclk);
        wdt_timeout <= 1'b0;
        repeat (4) @(posedge aclk);
        chk(core_hold, 1'b1);
        wait_load();
        chk(pc, VEC);
        chk(wdt_irq, src == 2 && ie);
        chk(rst_seen, 1'b0);
        chk(cyc - t0 >= LO && cyc - t0 <= HI, 1'b1);
        axi_rd(rst_pkg::A_CAUSE, rd, rr);
        chk(rd, exp_cause(src == 0 ? rst_pkg::P_STOP : 4'h6));
        axi_rd(rst_pkg::A_GPEN, rd, rr);
        chk(rd, {24'h0, gp});
    endtask

    initial begin
        {aclk, aresetn, rst_seen, ocd_seen} = '0;
        {stop_exec, dbg_rst_req, wdt_timeout, wdt_irq_mode, cpu_irq_en} = '0;
        {ai, gpio_in, errors, n_checks, cyc} = '0;
        void'($urandom(41));
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        wait_load();
        chk(pc, VEC);
        axi_rd(rst_pkg::A_CAUSE, rd, rr);
        axi_rd(rst_pkg::A_CAUSE, rd, rr);
        chk(rd, 32'h0);
        // Pulses of one to three samples, filter restarting between them
        rst_seen <= 1'b0;
        repeat (3) begin
            i_model.pin_low(1 + $urandom % 3);
            @(posedge aclk);
        end
        repeat (8) @(posedge aclk);
        chk(rst_seen, 1'b0);
        i_model.pin_low(4);
        wait_load();
        chk(rst_seen, 1'b1);
        // Pin held well past the time-out
        i_model.pin_low(30);
        chk(sys_rst_n, 1'b0);
        repeat (4) @(posedge aclk);
        chk(sys_rst_n, 1'b1);
        wait_load();
        axi_rd(rst_pkg::A_CAUSE, rd, rr);
        chk(rd, exp_cause(rst_pkg::P_EXT));
        // Debugger reset by register bit, then by request pulse
        for (int k = 0; k < 2; k++) begin
            rst_seen <= 1'b0;
            if (k == 0) axi_wr(rst_pkg::A_CTRL, 32'h1 << rst_pkg::CB_DBG);
            else dbg_rst_req <= 1'b1;
            @(posedge aclk);
            dbg_rst_req <= 1'b0;
            wait_load();
            chk(rst_seen, 1'b1);
            axi_rd(rst_pkg::A_CTRL, rd, rr);
            chk(rd[rst_pkg::CB_DBG], 1'b0);
            axi_rd(rst_pkg::A_CAUSE, rd, rr);
            chk(rd, exp_cause(rst_pkg::P_POR));
        end
        chk(ocd_seen, 1'b0);
        gp = (8'($urandom) & 8'h7E) | 8'h01;
        axi_wr(rst_pkg::A_GPEN, {24'h0, gp});
        for (int s = 0; s < 4; s++) stop_cycle(s > 2 ? 2 : s, s == 2);
        // Interrupt held off by the mask, raised, then cleared
        axi_wr(rst_pkg::A_IST, 32'hF);
        stop_cycle(0, 1'b0);
        chk(irq, 1'b0);
        axi_wr(rst_pkg::A_IMASK, 32'h1 << rst_pkg::EV_STOP);
        repeat (2) @(posedge aclk);
        chk(irq, 1'b1);
        axi_wr(rst_pkg::A_IST, 32'h1 << rst_pkg::EV_STOP);
        repeat (2) @(posedge aclk);
        chk(irq, 1'b0);
        axi_rd(12'h010, rd, rr);
        chk(rd, 32'h0);
        chk(rr, rst_pkg::RESP_SLV);
        complete_run();
    end
endmodule
